/* pkg/wb_out_pkg.sv */
// shared constants and carriers for the white-balance lookup output stage
package wb_out_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses on the 32-bit register bus)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W      = 12;
  localparam logic [11:0] CTRL_OFS    = 12'h000;
  localparam logic [11:0] STATUS_OFS  = 12'h004;
  localparam logic [11:0] PAGE_OFS    = 12'h008;
  localparam logic [1:0]  LUT_REGION  = 2'h1;    // addr[11:10], 0x400..0x7fc
  localparam logic [1:0]  PAGE_NONE   = 2'h3;    // no table behind this page

  // ----------------------------------------------------------------
  // table and colour layout
  // ----------------------------------------------------------------
  localparam int unsigned NUM_TABLES  = 3;
  localparam int unsigned LUT_DEPTH   = 256;
  localparam int unsigned COMP_W      = 8;
  localparam int unsigned COL_GREEN   = 1;       // red 0, green 1, blue 2

  // source colour depth codes
  localparam logic [1:0]  DEPTH_888   = 2'h0;
  localparam logic [1:0]  DEPTH_666   = 2'h1;
  localparam logic [1:0]  DEPTH_565   = 2'h2;

  // bus responses
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [1:0]  RESP_DECERR = 2'h3;

  // link clock bit pattern of one 7-bit frame: 2 high, 3 low, 2 high
  localparam logic [6:0]  LINK_CLK_PATTERN = 7'h63;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] depth;        // source colour depth code
    logic       pre_dither;   // pre_lut_dither enable
    logic       post_dither;  // post_lut_dither enable
    logic       out18;        // 18-bit output format
    logic       map_ovr;      // register overrides output_config_strap
    logic       map_sel;      // bit_map_select when overridden
    logic       reload_en;    // white-balance reload enable
    logic       wb_en;        // white-balance enable
  } ctrl_t;

  localparam ctrl_t CTRL_RST = '0;

  typedef struct packed {
    logic                             de;
    logic                             vs;
    logic                             hs;
    logic [NUM_TABLES-1:0][COMP_W-1:0] c;   // c[0] red, c[1] green, c[2] blue
  } pixel_t;

  typedef struct packed {
    logic [6:0]      clk;     // link_clock_a / link_clock_b bit pattern
    logic [3:0][6:0] lane;    // lane[3] is lane_three
  } lvds_frame_t;

endpackage

/* rtl/wb_lut_output.sv */
// white-balance lookup and display-link frame formatter with register slave
//
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps

module wb_lut_output
  import wb_out_pkg::*;
(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              nrst_i,
  // register bus write channels
  input  wire logic [ADDR_W-1:0] awaddr_i,
  input  wire logic              awvalid_i,
  output logic                   awready_o,
  input  wire logic [31:0]       wdata_i,
  input  wire logic [3:0]        wstrb_i,
  input  wire logic              wvalid_i,
  output logic                   wready_o,
  output logic [1:0]             bresp_o,
  output logic                   bvalid_o,
  input  wire logic              bready_i,
  // register bus read channels
  input  wire logic [ADDR_W-1:0] araddr_i,
  input  wire logic              arvalid_i,
  output logic                   arready_o,
  output logic [31:0]            rdata_o,
  output logic [1:0]             rresp_o,
  output logic                   rvalid_o,
  input  wire logic              rready_i,
  // recovered pixel side
  input  wire logic              pclk_i,
  input  wire pixel_t            pix_i,
  input  wire logic              output_config_strap_i,
  // display link side
  output lvds_frame_t            frame_o,
  output logic                   frame_valid_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    ctrl_t             ctrl;
    logic [1:0]        page;
    logic              loaded;      // white balance enabled once since reset
    logic [2:0]        strap_sync;
    logic              strap_f;
    logic [2:0]        pclk_sync;
    logic              pclk_f;
    pixel_t            pix_s1;
    pixel_t            pix_s2;
    pixel_t            pix_s3;
    logic              a_v;
    pixel_t            a_pix;
    logic              b_v;
    pixel_t            b_pix;
    logic              aw_full;
    logic [ADDR_W-1:0] aw_addr;
    logic              w_full;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic              fv;
    lvds_frame_t       frame;
  } state_t;

  state_t                            s_reg;
  state_t                            s_next;
  logic                              lut_we;
  logic [1:0]                        lut_tab;
  logic [7:0]                        lut_idx;
  logic [7:0]                        lut_wd;
  logic [NUM_TABLES-1:0][COMP_W-1:0] pix_idx;
  logic [NUM_TABLES-1:0][COMP_W-1:0] pix_rd;
  logic [NUM_TABLES-1:0][COMP_W-1:0] bus_rd;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // round an 8-bit value to 6 significant bits, saturating at the top
  function automatic logic [7:0] to6(input logic [7:0] c);
    logic [6:0] t;
    t = {1'b0, c[7:2]} + {6'h00, c[1]};
    return t[6] ? 8'hfc : {t[5:0], 2'b00};
  endfunction

  // table index from a component of the configured source depth
  function automatic logic [7:0] lut_index(input logic [7:0] c, input logic [1:0] d,
                                           input logic grn);
    logic [7:0] r;
    r = c;
    if (d == DEPTH_666 || (d == DEPTH_565 && grn))
      r = {c[5:0], 2'b00};
    else if (d == DEPTH_565)
      r = {c[4:0], 3'b000};
    return r;
  endfunction

  // spread one pixel over the four lanes of a 28-bit frame
  function automatic lvds_frame_t pack_frame(input pixel_t p, input logic out18,
                                             input logic msb3);
    logic [2:0][5:0] six;
    logic [2:0][1:0] two;
    lvds_frame_t     f;
    for (int i = 0; i < 3; i++)
    begin
      if (msb3 && !out18)
      begin
        six[i] = p.c[i][5:0];
        two[i] = p.c[i][7:6];
      end
      else
      begin
        six[i] = p.c[i][7:2];
        two[i] = p.c[i][1:0];
      end
    end
    f.clk     = LINK_CLK_PATTERN;
    f.lane[0] = {six[1][0], six[0]};
    f.lane[1] = {six[2][1:0], six[1][5:1]};
    f.lane[2] = {p.de, p.vs, p.hs, six[2][5:2]};
    f.lane[3] = out18 ? 7'h00 : {1'b0, two[2], two[1], two[0]};
    return f;
  endfunction

  // ----------------------------------------------------------------
  // colour tables
  // ----------------------------------------------------------------
  for (genvar gi = 0; gi < NUM_TABLES; gi++)
  begin : g_col
    logic [COMP_W-1:0] mem [LUT_DEPTH];
    assign pix_idx[gi] = lut_index(s_reg.a_pix.c[gi], s_reg.ctrl.depth, gi == COL_GREEN);
    always_ff @(posedge clk_i)
    begin
      if (lut_we && lut_tab == 2'(gi))
        mem[lut_idx] <= lut_wd;
    end
    assign pix_rd[gi] = mem[pix_idx[gi]];
    assign bus_rd[gi] = mem[araddr_i[9:2]];
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic   rise;
    logic   msb3;
    ctrl_t  nc;
    logic   [8:0] mask;
    pixel_t p;
    s_next  = s_reg;
    rise    = 1'b0;
    msb3    = 1'b0;
    nc      = s_reg.ctrl;
    mask    = '0;
    p       = s_reg.b_pix;
    lut_we  = 1'b0;
    lut_tab = s_reg.page;
    lut_idx = s_reg.aw_addr[9:2];
    lut_wd  = s_reg.w_data[7:0];

    // pin synchronisers; a change counts once stages two and three agree
    s_next.strap_sync = {s_reg.strap_sync[1:0], output_config_strap_i};
    s_next.pclk_sync  = {s_reg.pclk_sync[1:0], pclk_i};
    s_next.pix_s1     = pix_i;
    s_next.pix_s2     = s_reg.pix_s1;
    s_next.pix_s3     = s_reg.pix_s2;
    if (s_reg.strap_sync[1] == s_reg.strap_sync[2])
      s_next.strap_f = s_reg.strap_sync[2];
    if (s_reg.pclk_sync[1] == s_reg.pclk_sync[2])
    begin
      s_next.pclk_f = s_reg.pclk_sync[2];
      rise          = s_reg.pclk_sync[2] && !s_reg.pclk_f;
    end
    msb3 = s_reg.ctrl.map_ovr ? s_reg.ctrl.map_sel : s_reg.strap_f;

    // capture stage; pixel data has been stable for a whole link clock half
    s_next.a_v = rise;
    if (rise)
    begin
      s_next.a_pix = s_reg.pix_s3;
      for (int i = 0; i < 3; i++)
      begin
        if (s_reg.ctrl.pre_dither)
          s_next.a_pix.c[i] = to6(s_reg.pix_s3.c[i]);
      end
    end

    // lookup stage never stalls, so a table rewrite cannot drop pixels
    s_next.b_v = s_reg.a_v;
    if (s_reg.a_v)
    begin
      s_next.b_pix = s_reg.a_pix;
      if (s_reg.ctrl.wb_en)
        s_next.b_pix.c = pix_rd;
    end

    // format stage
    s_next.fv = s_reg.b_v;
    if (s_reg.b_v)
    begin
      for (int i = 0; i < 3; i++)
      begin
        if (s_reg.ctrl.post_dither)
          p.c[i] = to6(s_reg.b_pix.c[i]);
      end
      s_next.frame = pack_frame(p, s_reg.ctrl.out18, msb3);
    end

    // write address and data are taken independently, in either order
    if (s_reg.bvalid && bready_i)
      s_next.bvalid = 1'b0;
    if (awvalid_i && s_reg.awready)
    begin
      s_next.aw_full = 1'b1;
      s_next.aw_addr = awaddr_i;
    end
    if (wvalid_i && s_reg.wready)
    begin
      s_next.w_full = 1'b1;
      s_next.w_data = wdata_i;
      s_next.w_strb = wstrb_i;
    end
    if (s_reg.aw_full && s_reg.w_full && !s_reg.bvalid)
    begin
      s_next.aw_full = 1'b0;
      s_next.w_full  = 1'b0;
      s_next.bvalid  = 1'b1;
      s_next.bresp   = RESP_OKAY;
      if (s_reg.aw_addr == CTRL_OFS)
      begin
        mask = {s_reg.w_strb[1], {8{s_reg.w_strb[0]}}};
        nc   = ctrl_t'((s_reg.ctrl & ~mask) | (s_reg.w_data[8:0] & mask));
        s_next.ctrl   = nc;
        s_next.loaded = s_reg.loaded | nc.wb_en;
      end
      else if (s_reg.aw_addr == PAGE_OFS)
      begin
        if (s_reg.w_strb[0])
          s_next.page = s_reg.w_data[1:0];
      end
      else if (s_reg.aw_addr == STATUS_OFS)
        s_next.bresp = RESP_SLVERR;    // status is read-only
      else if (s_reg.aw_addr[11:10] == LUT_REGION)
      begin
        if (s_reg.page == PAGE_NONE)
          s_next.bresp = RESP_SLVERR;
        else if (s_reg.loaded && !s_reg.ctrl.reload_en)
          s_next.bresp = RESP_SLVERR;
        else
          lut_we = s_reg.w_strb[0];
      end
      else
        s_next.bresp = RESP_DECERR;
    end
    s_next.awready = !s_next.aw_full;
    s_next.wready  = !s_next.w_full;

    // read channel answers one cycle after the address is taken
    if (s_reg.rvalid && rready_i)
      s_next.rvalid = 1'b0;
    if (arvalid_i && s_reg.arready)
    begin
      s_next.rvalid = 1'b1;
      s_next.rresp  = RESP_OKAY;
      s_next.rdata  = '0;
      if (araddr_i == CTRL_OFS)
        s_next.rdata[8:0] = s_reg.ctrl;
      else if (araddr_i == STATUS_OFS)
        s_next.rdata[3:0] = {s_reg.strap_f, msb3,
                             s_reg.loaded && !s_reg.ctrl.reload_en, s_reg.loaded};
      else if (araddr_i == PAGE_OFS)
        s_next.rdata[1:0] = s_reg.page;
      else if (araddr_i[11:10] == LUT_REGION)
      begin
        if (s_reg.page == PAGE_NONE || s_reg.ctrl.reload_en)
          s_next.rresp = RESP_SLVERR;
        else
          s_next.rdata[7:0] = bus_rd[s_reg.page];
      end
      else
        s_next.rresp = RESP_DECERR;
    end
    s_next.arready = !s_next.rvalid;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // readies rise one edge after reset release, keeping reset constant-only
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  // outputs straight from the state register
  assign awready_o     = s_reg.awready;
  assign wready_o      = s_reg.wready;
  assign bresp_o       = s_reg.bresp;
  assign bvalid_o      = s_reg.bvalid;
  assign arready_o     = s_reg.arready;
  assign rdata_o       = s_reg.rdata;
  assign rresp_o       = s_reg.rresp;
  assign rvalid_o      = s_reg.rvalid;
  assign frame_o       = s_reg.frame;
  assign frame_valid_o = s_reg.fv;

endmodule

/* verification/wb_lut_output_properties.sv */
// assertion checker on the ports of the white-balance output stage
`timescale 1ns/1ps
module wb_lut_output_properties
  import wb_out_pkg::*;
(
  // clock and reset
  input wire logic        clk_i,
  input wire logic        nrst_i,
  // register bus
  input wire logic        awvalid_i,
  input wire logic        awready_o,
  input wire logic        wvalid_i,
  input wire logic        wready_o,
  input wire logic [1:0]  bresp_o,
  input wire logic        bvalid_o,
  input wire logic        bready_i,
  input wire logic        arvalid_i,
  input wire logic        arready_o,
  input wire logic [31:0] rdata_o,
  input wire logic        rvalid_o,
  input wire logic        rready_i,
  // link side
  input wire logic        pclk_i,
  input wire lvds_frame_t frame_o,
  input wire logic        frame_valid_o
);
  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  // ------------------------------------------------------------
  // link frames
  // ------------------------------------------------------------
  AST_LINK_CLK: assert property (frame_valid_o |-> frame_o.clk == 7'h63)
    else $error("link clock bits wrong");
  AST_ONE_FRAME: assert property (frame_valid_o |=> !frame_valid_o [*5])
    else $error("frames too close");
  AST_FRAME_HOLD: assert property (!frame_valid_o |-> $stable(frame_o))
    else $error("frame changed without strobe");
  // a missed pixel clock edge would silently drop a pixel on the glass
  AST_FRAME_LAT: assert property ($rose(pclk_i) |-> ##[3:10] frame_valid_o)
    else $error("no frame after pixel clock");

  // ------------------------------------------------------------
  // register bus
  // ------------------------------------------------------------
  AST_B_HOLD: assert property (bvalid_o && !bready_i |=> bvalid_o && $stable(bresp_o))
    else $error("write response dropped");
  AST_R_HOLD: assert property (rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o))
    else $error("read data dropped");
  AST_R_LAT: assert property (arvalid_i && arready_o |=> rvalid_o)
    else $error("read answer late");
  AST_B_LAT: assert property (awvalid_i && awready_o && wvalid_i && wready_o && !bvalid_o
    |-> ##2 bvalid_o)
    else $error("write answer late");
endmodule

bind wb_lut_output wb_lut_output_properties wb_lut_output_properties_i (
  .clk_i, .nrst_i, .awvalid_i, .awready_o, .wvalid_i, .wready_o, .bresp_o, .bvalid_o,
  .bready_i, .arvalid_i, .arready_o, .rdata_o, .rvalid_o, .rready_i, .pclk_i, .frame_o,
  .frame_valid_o
);

/* verification/lcd_panel_model.sv */
// display panel model that latches each link frame it receives
`timescale 1ns/1ps
module lcd_panel_model
  import wb_out_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  // display link
  input  wire lvds_frame_t frame_i,
  input  wire logic        frame_valid_i,
  // what the glass shows
  output lvds_frame_t      shown_o,
  output logic [15:0]      count_o
);
  // latch only on the strobe, so a stray change between frames goes unseen
  always_ff @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
    begin
      shown_o <= '0;
      count_o <= '0;
    end
    else if (frame_valid_i)
    begin
      shown_o <= frame_i;
      count_o <= count_o + 16'h1;
    end
endmodule

/* verification/wb_lut_output_tb.sv */
// self-checking bench for the white-balance output stage
`timescale 1ns/1ps
module wb_lut_output_tb
  import wb_out_pkg::*;
;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic              clk_i = 1'h0;
  logic              nrst_i = 1'h0;
  logic [ADDR_W-1:0] awaddr_i = '0;
  logic [ADDR_W-1:0] araddr_i = '0;
  logic [31:0]       wdata_i = '0;
  logic [3:0]        wstrb_i = 4'hf;
  logic              awvalid_i = 1'h0;
  logic              wvalid_i = 1'h0;
  logic              bready_i = 1'h0;
  logic              arvalid_i = 1'h0;
  logic              rready_i = 1'h0;
  logic              pclk_i = 1'h0;
  logic              output_config_strap_i = 1'h1;
  pixel_t            pix_i = '0;
  logic              awready_o, wready_o, bvalid_o, arready_o, rvalid_o, frame_valid_o;
  logic [1:0]        bresp_o, rresp_o;
  logic [31:0]       rdata_o;
  lvds_frame_t       frame_o, shown;
  logic [15:0]       fcnt;
  int                mismatches = 0;
  int                samples_checked = 0;
  int                cyc = 0;

  wb_lut_output wb_lut_output_i (
    .clk_i, .nrst_i, .awaddr_i, .awvalid_i, .awready_o, .wdata_i, .wstrb_i, .wvalid_i,
    .wready_o, .bresp_o, .bvalid_o, .bready_i, .araddr_i, .arvalid_i, .arready_o,
    .rdata_o, .rresp_o, .rvalid_o, .rready_i, .pclk_i, .pix_i, .output_config_strap_i,
    .frame_o, .frame_valid_o
  );
  lcd_panel_model lcd_panel_model_i (
    .clk_i, .nrst_i, .frame_i(frame_o), .frame_valid_i(frame_valid_o),
    .shown_o(shown), .count_o(fcnt)
  );

  initial
    forever #12.5 clk_i = ~clk_i;

  // the whole run needs well under half of this ceiling
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      $display("[ERR] %0t timeout", $time);
      test_done();
    end
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // ready is looked at mid-cycle, so the handshake edge is never raced
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_go;
    logic w_go;
    awaddr_i  <= a;
    wdata_i   <= d;
    awvalid_i <= 1'h1;
    wvalid_i  <= 1'h1;
    @(negedge clk_i);
    // each channel lets go at the edge that takes it, so none is taken twice
    while (awvalid_i || wvalid_i)
    begin
      aw_go = awready_o;
      w_go  = wready_o;
      @(posedge clk_i);
      if (aw_go)
        awvalid_i <= 1'h0;
      if (w_go)
        wvalid_i <= 1'h0;
      @(negedge clk_i);
    end
    while (!bvalid_o)
      @(negedge clk_i);
    @(posedge clk_i);
    bready_i <= 1'h1;
    // response taken at the handshake edge
    @(posedge clk_i);
    r        = bresp_o;
    bready_i <= 1'h0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr_i  <= a;
    arvalid_i <= 1'h1;
    @(negedge clk_i);
    while (!arready_o)
      @(negedge clk_i);
    @(posedge clk_i);
    arvalid_i <= 1'h0;
    @(negedge clk_i);
    while (!rvalid_o)
      @(negedge clk_i);
    @(posedge clk_i);
    rready_i <= 1'h1;
    // read data taken at the handshake edge
    @(posedge clk_i);
    d        = rdata_o;
    r        = rresp_o;
    rready_i <= 1'h0;
  endtask

  task automatic wchk(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
    logic [1:0] r;
    wr(a, d, r);
    chk(64'(r), 64'(e), "bresp");
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(64'({d, r}), 64'({e, er}), "read");
  endtask

  function automatic logic [11:0] la(input logic [7:0] n);
    return {2'h1, n, 2'h0};
  endfunction

  // distinct entries per table, tables told apart by the top bits
  function automatic logic [7:0] lv(input logic [1:0] t, input logic [7:0] n);
    return n ^ {t, 6'h2b};
  endfunction

  function automatic lvds_frame_t fexp(input pixel_t p, input logic m, input logic o18);
    lvds_frame_t     f;
    logic [2:0][5:0] s;
    logic [2:0][1:0] t;
    for (int k = 0; k < 3; k++)
    begin
      s[k] = (m && !o18) ? p.c[k][5:0] : p.c[k][7:2];
      t[k] = o18 ? 2'h0 : (m ? p.c[k][7:6] : p.c[k][1:0]);
    end
    f.clk     = 7'h63;
    f.lane[0] = {s[1][0], s[0]};
    f.lane[1] = {s[2][1:0], s[1][5:1]};
    f.lane[2] = {p.de, p.vs, p.hs, s[2][5:2]};
    f.lane[3] = {1'h0, t[2], t[1], t[0]};
    return f;
  endfunction

  // one 200 ns link clock period, then the clock stands low while the frame drains
  task automatic px(input pixel_t p, input pixel_t q, input logic m, input logic o18);
    logic [15:0] n;
    n = fcnt;
    pix_i  <= p;
    pclk_i <= 1'h0;
    repeat (4) @(posedge clk_i);
    pclk_i <= 1'h1;
    repeat (4) @(posedge clk_i);
    pclk_i <= 1'h0;
    repeat (8) @(posedge clk_i);
    chk(64'(fcnt - n), 64'h1, "frame count");
    chk(64'(shown), 64'(fexp(q, m, o18)), "frame");
  endtask

  // round to six significant bits with saturation, written apart from the design
  function automatic logic [7:0] r6(input logic [7:0] c);
    return (c >= 8'hfe) ? 8'hfc : ((c + 8'h02) & 8'hfc);
  endfunction

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    rchk(CTRL_OFS, 32'h0, RESP_OKAY);       // starts off
    rchk(STATUS_OFS, 32'hc, RESP_OKAY);     // strap seen
    wchk(STATUS_OFS, 32'h1, RESP_SLVERR);   // read only
    rchk(12'h100, 32'h0, RESP_DECERR);      // unmapped
    wchk(PAGE_OFS, 32'h3, RESP_OKAY);       // page select
    wchk(la(8'h10), 32'h1, RESP_SLVERR);    // no table
    $display("regs test done");
  endtask

  task automatic t_pass();
    pixel_t p;
    logic   m, o, v;
    p = {3'h5, 8'h93, 8'h5a, 8'hc6};
    for (int i = 0; i < 8; i++)
    begin
      {v, o, m} = 3'(i);
      wchk(CTRL_OFS, {27'h0, o, v, m, 2'h0}, RESP_OKAY);
      output_config_strap_i <= m ^ v;
      px(p, p, m, o);                       // formats and maps
    end
    $display("pass test done");
  endtask

  task automatic t_load();
    for (int t = 0; t < 3; t++)
    begin
      wchk(PAGE_OFS, 32'(t), RESP_OKAY);    // red green blue
      for (int n = 0; n < 256; n++)
        wchk(la(8'(n)), {24'h0, lv(2'(t), 8'(n))}, RESP_OKAY); // full tables
    end
    rchk(la(8'hff), {24'h0, lv(2'h2, 8'hff)}, RESP_OKAY);  // blue read
    wchk(PAGE_OFS, 32'h1, RESP_OKAY);
    rchk(la(8'h00), {24'h0, lv(2'h1, 8'h00)}, RESP_OKAY);  // green read
    $display("load test done");
  endtask

  task automatic t_wb();
    pixel_t p, q;
    p = {3'h1, 8'h03, 8'hfe, 8'h80};
    q = p;
    for (int k = 0; k < 3; k++)
      q.c[k] = lv(2'(k), p.c[k]);
    output_config_strap_i <= 1'h1;
    wchk(CTRL_OFS, 32'h1, RESP_OKAY);       // enable
    px(p, q, 1'h1, 1'h0);                   // lookup
    wchk(la(8'h05), 32'hff, RESP_SLVERR);   // locked
    rchk(la(8'h05), {24'h0, lv(2'h1, 8'h05)}, RESP_OKAY);  // entry kept
    rchk(STATUS_OFS, 32'hf, RESP_OKAY);     // lock flag
    $display("enable test done");
  endtask

  task automatic t_depth();
    pixel_t p, q;
    p = {3'h4, 8'h1e, 8'h21, 8'h13};
    for (int d = 1; d < 3; d++)
    begin
      wchk(CTRL_OFS, {23'h0, 2'(d), 7'h1}, RESP_OKAY);
      q      = p;
      q.c[1] = lv(2'h1, {p.c[1][5:0], 2'h0});
      for (int k = 0; k < 3; k += 2)
        q.c[k] = lv(2'(k), d == 1 ? {p.c[k][5:0], 2'h0} : {p.c[k][4:0], 3'h0});
      px(p, q, 1'h1, 1'h0);                 // short index
    end
    $display("depth test done");
  endtask

  task automatic t_reload();
    pixel_t      p, q;
    logic [31:0] d;
    logic [1:0]  r;
    p      = {3'h4, 8'h00, 8'h5a, 8'h00};
    q      = p;
    q.c[0] = lv(2'h0, 8'h00);
    q.c[1] = 8'h11;
    q.c[2] = lv(2'h2, 8'h00);
    wchk(CTRL_OFS, 32'h3, RESP_OKAY);       // reload on
    wchk(la(8'h5a), 32'h11, RESP_OKAY);     // partial update
    rd(la(8'h5a), d, r);
    chk(64'({d, r}), 64'({32'h0, RESP_SLVERR}), "reload read");
    px(p, q, 1'h1, 1'h0);                   // new entry
    $display("reload test done");
  endtask

  task automatic t_dither();
    pixel_t p, q;
    p = {3'h2, 8'h2e, 8'h07, 8'h15};
    q = p;
    // 666 source looked up to 8 bits, then rounded back to 6 after the table
    wchk(CTRL_OFS, 32'hb3, RESP_OKAY);      // post_lut_dither on
    for (int k = 0; k < 3; k++)
      q.c[k] = r6(lv(2'(k), {p.c[k][5:0], 2'h0}));
    px(p, q, 1'h1, 1'h1);                   // rounding after lookup
    // 888 source rounded before it indexes the table
    wchk(CTRL_OFS, 32'h43, RESP_OKAY);      // pre_lut_dither on
    for (int k = 0; k < 3; k++)
      q.c[k] = lv(2'(k), r6(p.c[k]));
    px(p, q, 1'h1, 1'h0);                   // rounding before lookup
    $display("dither test done");
  endtask

  initial
  begin
    repeat (8) @(posedge clk_i);
    nrst_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    t_regs();
    t_pass();
    t_load();
    t_wb();
    t_depth();
    t_reload();
    t_dither();
    test_done();
  end
endmodule
